// file: hw/tccr_top.sv
// Purpose: 16-bit timer/counter with reload, capture and compare, APB slave
// Assumes: mclk_i is the oscillator clock; pins are synchronous to it
// Notes: Counts once per machine cycle of twelve clocks at most
// Operation
// - The counter is 16 bits wide, with an optional 2:1 prescaler and optional gate input.
// - Four 16-bit capture/compare registers each own one port pin.
// - In auto reload mode an overflow loads the reload value into the counter.
// - In pin reload mode a falling reload pin edge loads the counter and raises a request.
// - In pin capture mode a pin transition latches the counter into that channel.
// - In software capture mode a low-byte write latches the counter into that channel.
// - A compare match drives the channel output event and requests an interrupt.
// - In compare mode 0 a match drives the pin high and an overflow drives it low.
// - In compare mode 1 a match drives a software level and overflow leaves the pin alone.
// - The four channel pins also act as external interrupt inputs 3 to 6.
// - Timer mode counts at 1/12 of the clock, counter mode at most 1/24 of it.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module tccr_top (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic count_gate_input_pin_i,
   input wire logic reload_trigger_pin_i,
   input wire logic [3:0] capcmp_pin_i,
   output logic [3:0] capcmp_pin_o,
   output logic [3:0] capcmp_pin_oe_o,
   output logic timer_irq_o,
   output logic cmp_irq_o,
   output logic [3:0] ext_irq_o
);
   logic [6:0] ctrl_reg, ctrl_next;
   logic [7:0] ccmode_reg, ccmode_next;
   logic [3:0] cmplvl_reg, cmplvl_next;
   logic [9:0] status_reg, status_next;
   logic [15:0] count_reg, count_next;
   logic [15:0] reload_reg, reload_next;
   logic [3:0] mc_cnt_reg, mc_cnt_next;
   logic pre_reg, pre_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic timer_irq_reg, timer_irq_next;
   logic cmp_irq_reg, cmp_irq_next;
   logic [31:0] wmask, rdata_mux;
   logic hit, setup, wr_fire;
   logic mc_tick, raw_tick, inc, ovf, cnt_wr, pin_rld, cnt_chg;
   logic cnt_fall, rld_fall;
   logic [9:0] st_set, st_clr;
   logic [3:0] cc_wr, pin_rise, pin_fall, ch_match;
   logic [15:0] ch_cc [4];
   tccr_pkg::tccr_rld_t rld_mode;

   assign rld_mode = tccr_pkg::tccr_rld_t'(ctrl_reg[tccr_pkg::CTL_RLD +: 2]);
   assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   assign setup = psel_i & ~penable_i;
   assign wr_fire = psel_i & penable_i & pready_reg & pwrite_i;

   always_comb begin
      mc_tick = (mc_cnt_reg == tccr_pkg::MC_LAST);
      mc_cnt_next = mc_tick ? 4'h0 : 4'(mc_cnt_reg + 4'h1);
   end

   // count pin sampled once per machine cycle
   tccr_edge u_cnt_edge (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .en_i(mc_tick),
      .pin_i(count_gate_input_pin_i),
      .rise_o(),
      .fall_o(cnt_fall)
   );

   // Reload trigger sampled like the count pin
   tccr_edge u_rld_edge (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .en_i(mc_tick),
      .pin_i(reload_trigger_pin_i),
      .rise_o(),
      .fall_o(rld_fall)
   );

   // tick source, gate and 2:1 prescaler
   always_comb begin
      if (ctrl_reg[tccr_pkg::CTL_EXT]) begin
         raw_tick = cnt_fall;
      end else begin
         raw_tick = mc_tick & (~ctrl_reg[tccr_pkg::CTL_GATE] | count_gate_input_pin_i);
      end
      raw_tick = raw_tick & ctrl_reg[tccr_pkg::CTL_RUN];
      pre_next = raw_tick ? ~pre_reg : pre_reg;
      inc = raw_tick & (~ctrl_reg[tccr_pkg::CTL_PRE] | pre_reg);
      ovf = inc & (count_reg == tccr_pkg::CNT_MAX);
   end

   // Counter: software write, then pin reload, then overflow, then increment
   always_comb begin
      cnt_wr = wr_fire & (paddr_i == tccr_pkg::OFS_COUNT);
      pin_rld = (rld_mode == tccr_pkg::RLD_PIN) & rld_fall;
      count_next = count_reg;
      if (cnt_wr) begin
         count_next = (count_reg & ~wmask[15:0]) | (pwdata_i[15:0] & wmask[15:0]);
      end else if (pin_rld) begin
         count_next = reload_reg;
      end else if (ovf) begin
         count_next = (rld_mode == tccr_pkg::RLD_AUTO) ? reload_reg : tccr_pkg::CNT_RST;
      end else if (inc) begin
         count_next = count_reg + 16'h0001;
      end
      cnt_chg = cnt_wr | pin_rld | inc;
   end

   // four capture/compare channels with their pins
   genvar gi;
   generate
      for (gi = 0; gi < tccr_pkg::NUM_CC; gi++) begin : g_ch
         assign cc_wr[gi] = wr_fire
            & (paddr_i == 8'(tccr_pkg::OFS_CC0 + gi * tccr_pkg::OFS_CC_STEP));
         tccr_edge u_pin_edge (
            .mclk_i(mclk_i),
            .rstn_i(rstn_i),
            .en_i(1'b1),
            .pin_i(capcmp_pin_i[gi]),
            .rise_o(pin_rise[gi]),
            .fall_o(pin_fall[gi])
         );
         tccr_chan u_chan (
            .mclk_i(mclk_i),
            .rstn_i(rstn_i),
            .mode_i(ccmode_reg[2 * gi +: 2]),
            .cmp_mode_i(ctrl_reg[tccr_pkg::CTL_CMPM]),
            .sw_level_i(cmplvl_reg[gi]),
            .count_i(count_reg),
            .cnt_new_i(count_next),
            .cnt_chg_i(cnt_chg),
            .ovf_i(ovf),
            .pin_edge_i(pin_rise[gi] | pin_fall[gi]),
            .wr_i(cc_wr[gi]),
            .wstrb_i(pstrb_i[1:0]),
            .wdata_i(pwdata_i[15:0]),
            .cc_o(ch_cc[gi]),
            .pin_o(capcmp_pin_o[gi]),
            .oe_o(capcmp_pin_oe_o[gi]),
            .match_o(ch_match[gi])
         );
      end
   endgenerate

   // Status flags; a set in the clearing cycle survives
   always_comb begin
      st_set = '0;
      st_set[tccr_pkg::ST_OVF] = ovf;
      st_set[tccr_pkg::ST_EXF] = pin_rld;
      st_set[tccr_pkg::ST_MATCH +: 4] = ch_match;
      // rising pin edge is an external interrupt
      st_set[tccr_pkg::ST_INT +: 4] = pin_rise;
      st_clr = '0;
      if (wr_fire && paddr_i == tccr_pkg::OFS_STATUS) begin
         st_clr = pwdata_i[9:0] & wmask[9:0];
      end
      status_next = (status_reg & ~st_clr) | st_set;
      // one timer request from both flags
      timer_irq_next = status_next[tccr_pkg::ST_OVF] | status_next[tccr_pkg::ST_EXF];
      // compare request from any match flag
      cmp_irq_next = |status_next[tccr_pkg::ST_MATCH +: 4];
   end

   // Plain control registers honour byte lanes
   always_comb begin
      ctrl_next = ctrl_reg;
      ccmode_next = ccmode_reg;
      cmplvl_next = cmplvl_reg;
      reload_next = reload_reg;
      if (wr_fire && paddr_i == tccr_pkg::OFS_CTRL) begin
         ctrl_next = (ctrl_reg & ~wmask[6:0]) | (pwdata_i[6:0] & wmask[6:0]);
      end else if (wr_fire && paddr_i == tccr_pkg::OFS_CCMODE) begin
         ccmode_next = (ccmode_reg & ~wmask[7:0]) | (pwdata_i[7:0] & wmask[7:0]);
      end else if (wr_fire && paddr_i == tccr_pkg::OFS_CMPLVL) begin
         cmplvl_next = (cmplvl_reg & ~wmask[3:0]) | (pwdata_i[3:0] & wmask[3:0]);
      end else if (wr_fire && paddr_i == tccr_pkg::OFS_RELOAD) begin
         reload_next = (reload_reg & ~wmask[15:0]) | (pwdata_i[15:0] & wmask[15:0]);
      end
   end

   // Read decode; unmapped addresses answer with an error
   always_comb begin
      rdata_mux = 32'h0000_0000;
      hit = 1'b1;
      if (paddr_i == tccr_pkg::OFS_CTRL) begin
         rdata_mux[6:0] = ctrl_reg;
      end else if (paddr_i == tccr_pkg::OFS_CCMODE) begin
         rdata_mux[7:0] = ccmode_reg;
      end else if (paddr_i == tccr_pkg::OFS_CMPLVL) begin
         rdata_mux[3:0] = cmplvl_reg;
      end else if (paddr_i == tccr_pkg::OFS_STATUS) begin
         rdata_mux[9:0] = status_reg;
      end else if (paddr_i == tccr_pkg::OFS_COUNT) begin
         rdata_mux[15:0] = count_reg;
      end else if (paddr_i == tccr_pkg::OFS_RELOAD) begin
         rdata_mux[15:0] = reload_reg;
      end else if (|cc_wr || paddr_i[7:4] == 4'h1 || paddr_i[7:4] == 4'h2) begin
         hit = 1'b0;
         for (int k = 0; k < tccr_pkg::NUM_CC; k++) begin
            if (paddr_i == 8'(tccr_pkg::OFS_CC0 + k * tccr_pkg::OFS_CC_STEP)) begin
               rdata_mux[15:0] = ch_cc[k];
               hit = 1'b1;
            end
         end
      end else begin
         hit = 1'b0;
      end
   end

   // Answer is prepared in setup so the access phase never waits
   always_comb begin
      pready_next = setup;
      pslverr_next = setup & ~hit;
      prdata_next = (setup && !pwrite_i) ? rdata_mux : prdata_reg;
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_reg <= tccr_pkg::CTRL_RST;
         ccmode_reg <= tccr_pkg::CCMODE_RST;
         cmplvl_reg <= tccr_pkg::CMPLVL_RST;
         status_reg <= tccr_pkg::STATUS_RST;
         count_reg <= tccr_pkg::CNT_RST;
         reload_reg <= tccr_pkg::CNT_RST;
         mc_cnt_reg <= 4'h0;
         pre_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         timer_irq_reg <= 1'b0;
         cmp_irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         ccmode_reg <= ccmode_next;
         cmplvl_reg <= cmplvl_next;
         status_reg <= status_next;
         count_reg <= count_next;
         reload_reg <= reload_next;
         mc_cnt_reg <= mc_cnt_next;
         pre_reg <= pre_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         timer_irq_reg <= timer_irq_next;
         cmp_irq_reg <= cmp_irq_next;
      end
   end

   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign timer_irq_o = timer_irq_reg;
   assign cmp_irq_o = cmp_irq_reg;
   assign ext_irq_o = status_reg[tccr_pkg::ST_INT +: 4];

   // Checks on counter, channel 0 and flags
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_ch0_match_mode0;
      ch_match[0] && !ctrl_reg[tccr_pkg::CTL_CMPM] && ccmode_reg[1:0] == 2'h3;
   endsequence
   sequence s_ovf_no_match;
      ovf && !cnt_wr && !(cnt_chg && count_next == ch_cc[0]);
   endsequence

   a_mc_period: assert property (mc_tick |-> ##12 mc_tick)
      else $error("machine cycle is not twelve clocks");
   a_gate_hold: assert property (ctrl_reg[tccr_pkg::CTL_GATE] && !ctrl_reg[tccr_pkg::CTL_EXT]
      && !count_gate_input_pin_i && !cnt_wr && !pin_rld |=> $stable(count_reg))
      else $error("counter moved while gated off");
   a_reload_auto: assert property (ovf && !cnt_wr && !pin_rld && rld_mode == tccr_pkg::RLD_AUTO
      |=> count_reg == $past(reload_reg))
      else $error("auto reload missing");
   a_reload_pin: assert property (pin_rld && !cnt_wr
      |=> count_reg == $past(reload_reg) && status_reg[tccr_pkg::ST_EXF])
      else $error("pin reload missing");
   a_capture_pin: assert property (ccmode_reg[1:0] == 2'h1 && (pin_rise[0] || pin_fall[0])
      |=> ch_cc[0] == $past(count_reg))
      else $error("pin capture missing");
   a_capture_sw: assert property (ccmode_reg[1:0] == 2'h2 && cc_wr[0] && pstrb_i[0]
      |=> ch_cc[0] == $past(count_reg))
      else $error("software capture missing");
   a_cmp_request: assert property (ch_match[0] |=> status_reg[tccr_pkg::ST_MATCH] && cmp_irq_o)
      else $error("compare request missing");
   a_cmp_mode0: assert property (s_ch0_match_mode0 |-> capcmp_pin_o[0])
      else $error("compare mode 0 pin not high");
   a_cmp_ovf_low: assert property (s_ovf_no_match ##0 !ctrl_reg[tccr_pkg::CTL_CMPM]
      && ccmode_reg[1:0] == 2'h3 |=> !capcmp_pin_o[0])
      else $error("compare pin not cleared on overflow");
   a_cmp_mode1: assert property (s_ovf_no_match ##0 ctrl_reg[tccr_pkg::CTL_CMPM]
      |=> $stable(capcmp_pin_o[0]))
      else $error("compare mode 1 pin moved on overflow");
   a_ext_int: assert property (pin_rise[0] |=> ext_irq_o[0])
      else $error("external interrupt flag missing");
   a_timer_irq: assert property (ovf |=> status_reg[tccr_pkg::ST_OVF] && timer_irq_o)
      else $error("overflow request missing");
endmodule : tccr_top

// file: hw/tccr_pkg.sv
// Purpose: Shared constants and types for the timer with capture/compare/reload
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package tccr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CCMODE = 8'h04;
   localparam logic [7:0] OFS_CMPLVL = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_RELOAD = 8'h14;
   localparam logic [7:0] OFS_CC0 = 8'h18;
   localparam logic [7:0] OFS_CC_STEP = 8'h04;
   localparam int NUM_CC = 4;

   // Control field positions
   localparam int CTL_RUN = 0;
   localparam int CTL_PRE = 1;
   localparam int CTL_GATE = 2;
   localparam int CTL_EXT = 3;
   localparam int CTL_RLD = 4;
   localparam int CTL_CMPM = 6;
   localparam int CTL_W = 7;

   // Status field positions
   localparam int ST_OVF = 0;
   localparam int ST_EXF = 1;
   localparam int ST_MATCH = 2;
   localparam int ST_INT = 6;
   localparam int ST_W = 10;

   // Reset values
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam logic [7:0] CCMODE_RST = 8'h00;
   localparam logic [3:0] CMPLVL_RST = 4'h0;
   localparam logic [9:0] STATUS_RST = 10'h000;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;

   // Oscillator clocks per machine cycle
   localparam int MC_DIV = 12;
   localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);

   // Reload mode, gray-coded
   typedef enum logic [1:0] {
      RLD_NONE = 2'h0,
      RLD_AUTO = 2'h1,
      RLD_PIN = 2'h3,
      RLD_RSVD = 2'h2
   } tccr_rld_t;

   // Capture/compare channel mode
   typedef enum logic [1:0] {
      CCM_OFF = 2'h0,
      CCM_CAP_PIN = 2'h1,
      CCM_CMP = 2'h3,
      CCM_CAP_SW = 2'h2
   } tccr_ccm_t;
endpackage : tccr_pkg

// file: hw/tccr_edge.sv
// Purpose: Edge detector on a pin sampled when enabled
// Assumes: Pin synchronous to the clock
// Notes: Idle level is high, matching a pulled-up port pin
`timescale 1ns/1ns
module tccr_edge (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire logic pin_i,
   output logic rise_o,
   output logic fall_o
);
   logic prev_reg;
   logic prev_next;

   // Previous sample only moves on enabled cycles
   always_comb begin
      prev_next = en_i ? pin_i : prev_reg;
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= prev_next;
      end
   end

   assign rise_o = en_i & ~prev_reg & pin_i;
   assign fall_o = en_i & prev_reg & ~pin_i;
endmodule : tccr_edge

// file: hw/tccr_chan.sv
// Purpose: One 16-bit capture/compare register with its pin
// Assumes: Counter change is flagged by cnt_chg_i with the value it takes
// Notes: Match is checked against the value the counter is about to hold
`timescale 1ns/1ns
module tccr_chan (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [1:0] mode_i,
   input wire logic cmp_mode_i,
   input wire logic sw_level_i,
   input wire logic [15:0] count_i,
   input wire logic [15:0] cnt_new_i,
   input wire logic cnt_chg_i,
   input wire logic ovf_i,
   input wire logic pin_edge_i,
   input wire logic wr_i,
   input wire logic [1:0] wstrb_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] cc_o,
   output logic pin_o,
   output logic oe_o,
   output logic match_o
);
   tccr_pkg::tccr_ccm_t mode;
   logic [15:0] cc_reg, cc_next;
   logic pin_reg, pin_next;
   logic match_reg, match_next;
   logic oe_reg, oe_next;
   logic match;

   assign mode = tccr_pkg::tccr_ccm_t'(mode_i);
   assign match = (mode == tccr_pkg::CCM_CMP) & cnt_chg_i & (cnt_new_i == cc_reg);

   // Capture beats a plain store; low-byte write is the trigger in software mode
   // capture triggers
   always_comb begin
      cc_next = cc_reg;
      if (mode == tccr_pkg::CCM_CAP_PIN && pin_edge_i) begin
         cc_next = count_i;
      end else if (mode == tccr_pkg::CCM_CAP_SW && wr_i && wstrb_i[0]) begin
         cc_next = count_i;
      end else if (wr_i) begin
         if (wstrb_i[0]) begin
            cc_next[7:0] = wdata_i[7:0];
         end
         if (wstrb_i[1]) begin
            cc_next[15:8] = wdata_i[15:8];
         end
      end
   end

   // Pin level: match wins over an overflow landing in the same cycle
   // compare pin level
   always_comb begin
      pin_next = pin_reg;
      match_next = match;
      oe_next = (mode == tccr_pkg::CCM_CMP); // Registered so the pin enable leaves a flop
      if (match) begin
         pin_next = cmp_mode_i ? sw_level_i : 1'b1;
      end else if (ovf_i && !cmp_mode_i) begin
         pin_next = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cc_reg <= tccr_pkg::CNT_RST;
         pin_reg <= 1'b0;
         match_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         cc_reg <= cc_next;
         pin_reg <= pin_next;
         match_reg <= match_next;
         oe_reg <= oe_next;
      end
   end

   assign cc_o = cc_reg;
   assign pin_o = pin_reg;
   assign oe_o = oe_reg;
   assign match_o = match_reg;
endmodule : tccr_chan

// file: dv/tccr_pins_model.sv
// Purpose: Far-side pins model for the timer block
// Assumes: Port pins are pulled up while nobody drives them
// Notes: Tasks are called from the testbench
`timescale 1ns/1ns
module tccr_pins_model (
   input wire logic mclk_i,
   input wire logic [3:0] pin_o_i,
   input wire logic [3:0] oe_i,
   output logic gate_o,
   output logic reload_o,
   output logic [3:0] wire_o
);
   logic [3:0] drv;
   initial begin
      drv = 4'hF;
      gate_o = 1'b1;
      reload_o = 1'b1;
   end
   assign wire_o = (oe_i & pin_o_i) | (~oe_i & drv);
   task automatic reload_pulse(input int n);
      @(posedge mclk_i) reload_o <= 1'b0;
      repeat (n) @(posedge mclk_i);
      reload_o <= 1'b1;
   endtask : reload_pulse
   task automatic set_gate(input logic v);
      @(posedge mclk_i) gate_o <= v;
   endtask : set_gate
   // count pulses, kept just above the fastest legal spacing
   task automatic count_pulses(input int n);
      repeat (n) begin
         @(posedge mclk_i) gate_o <= 1'b0;
         repeat (13) @(posedge mclk_i);
         gate_o <= 1'b1;
         repeat (13) @(posedge mclk_i);
      end
   endtask : count_pulses
   // Pull one channel pin low for a while
   task automatic cc_toggle(input int ch, input int n);
      @(posedge mclk_i) drv[ch] <= 1'b0;
      repeat (n) @(posedge mclk_i);
      drv[ch] <= 1'b1;
   endtask : cc_toggle
endmodule : tccr_pins_model

// file: dv/timer2_capture_compare_reload_test.sv
// Purpose: Self-checking bench for the timer with capture/compare/reload
// Assumes: Zero-wait APB slave, pins synchronous to mclk_i
// Notes: Register model is an array updated on every wr call, not on raw apb writes
`timescale 1ns/1ns
module timer2_capture_compare_reload_test;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0] pstrb_i = 4'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, gate_pin, reload_pin, timer_irq_o, cmp_irq_o;
   logic [3:0] cc_wire, capcmp_pin_o, capcmp_pin_oe_o, ext_irq_o, prev;
   int failures = 0;
   int n_tests = 0;
   int k;
   logic [31:0] lfsr = 32'h3A8E;
   logic [31:0] r;
   logic e;
   logic [31:0] mdl [10] = '{default: 32'h0};
   logic [31:0] msk [10] = '{32'h7F, 32'hFF, 32'hF, 32'h3FF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
      32'hFFFF, 32'hFFFF, 32'hFFFF};
   int ri [7] = '{2, 4, 5, 6, 7, 8, 9};
   always #5 mclk_i = ~mclk_i;
   tccr_top u_tccr_top (.mclk_i(mclk_i), .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .count_gate_input_pin_i(gate_pin), .reload_trigger_pin_i(reload_pin),
      .capcmp_pin_i(cc_wire), .capcmp_pin_o(capcmp_pin_o), .capcmp_pin_oe_o(capcmp_pin_oe_o),
      .timer_irq_o(timer_irq_o), .cmp_irq_o(cmp_irq_o), .ext_irq_o(ext_irq_o));
   tccr_pins_model u_tccr_pins_model (.mclk_i(mclk_i), .pin_o_i(capcmp_pin_o),
      .oe_i(capcmp_pin_oe_o), .gate_o(gate_pin), .reload_o(reload_pin), .wire_o(cc_wire));
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
      n_tests++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         failures++;
         $display("MISMATCH %s expected %0d..%0d seen %h", nm, lo, hi, got);
      end
   endtask : chk_rng
   // Setup, then access held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int t;
      t = 0;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      paddr_i <= a;
      pwrite_i <= w;
      pwdata_i <= d;
      pstrb_i <= s;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      #1;
      while (pready_o !== 1'b1 && t < 16) begin
         @(posedge mclk_i);
         #1;
         t++;
      end
      if (t == 16) begin
         failures++;
         give_verdict();
      end
      r = prdata_o;
      e = pslverr_o;
      @(posedge mclk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // Callers look at outputs only once this edge has settled
      #1;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
      mdl[a[5:2]] = d & msk[a[5:2]];
   endtask : wr
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask : rd
   // Bounded wait for the status bit, then stop on timeout
   task automatic poll(input int b);
      k = 0;
      do begin
         rd(tccr_pkg::OFS_STATUS);
         k++;
      end while (r[b] !== 1'b1 && k < 60);
      if (k == 60) begin
         failures++;
         give_verdict();
      end
   endtask : poll
   initial begin
      repeat (5) @(posedge mclk_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rd(8'(4 * i));
         chk("reset reg", 32'h0, r);
      end
      chk("idle outs", 32'h0, {timer_irq_o, cmp_irq_o, ext_irq_o, capcmp_pin_oe_o, capcmp_pin_o});
      rd(8'h28);
      chk("unmapped data", 32'h0, r);
      chk("unmapped error", 32'h1, {31'h0, e});
      foreach (ri[j]) begin
         lfsr = nxt(lfsr);
         wr(8'(4 * ri[j]), lfsr);
         rd(8'(4 * ri[j]));
         chk("reg rw", mdl[ri[j]], r);
      end
      // Rate with and without prescaler, then gate held off
      for (int p = 0; p < 2; p++) begin
         wr(tccr_pkg::OFS_COUNT, 32'h0);
         wr(tccr_pkg::OFS_CTRL, 32'(1 + 2 * p));
         repeat (240) @(posedge mclk_i);
         wr(tccr_pkg::OFS_CTRL, 32'h0);
         rd(tccr_pkg::OFS_COUNT);
         chk_rng("rate", 243 / (12 << p) - 1, 243 / (12 << p) + 1, r);
      end
      u_tccr_pins_model.set_gate(1'b0);
      wr(tccr_pkg::OFS_COUNT, 32'h0);
      wr(tccr_pkg::OFS_CTRL, 32'h5);
      repeat (100) @(posedge mclk_i);
      wr(tccr_pkg::OFS_CTRL, 32'h0);
      rd(tccr_pkg::OFS_COUNT);
      chk("gated", 32'h0, r);
      u_tccr_pins_model.set_gate(1'b1);
      wr(tccr_pkg::OFS_COUNT, 32'h0);
      wr(tccr_pkg::OFS_CTRL, 32'h9);
      u_tccr_pins_model.count_pulses(5);
      wr(tccr_pkg::OFS_CTRL, 32'h0);
      rd(tccr_pkg::OFS_COUNT);
      chk("events", 32'h5, r);
      // Every reload mode against a trigger edge
      for (int m = 0; m < 4; m++) begin
         wr(tccr_pkg::OFS_STATUS, 32'h3FF);
         wr(tccr_pkg::OFS_RELOAD, 32'h1234);
         wr(tccr_pkg::OFS_COUNT, 32'h0);
         wr(tccr_pkg::OFS_CTRL, 32'(1 + 16 * m));
         u_tccr_pins_model.reload_pulse(13);
         repeat (3) @(posedge mclk_i);
         rd(tccr_pkg::OFS_STATUS);
         chk("ext flag", 32'(m == 3), {31'h0, r[1]});
         chk("timer irq", 32'(m == 3), {31'h0, timer_irq_o});
         rd(tccr_pkg::OFS_COUNT);
         chk_rng("pin reload", (m == 3) ? 32'h1234 : 0, (m == 3) ? 32'h1237 : 4, r);
         wr(tccr_pkg::OFS_CTRL, 32'h0);
      end
      // Overflow with no reload, then with auto reload
      for (int m = 0; m < 2; m++) begin
         lfsr = nxt(lfsr);
         wr(tccr_pkg::OFS_STATUS, 32'h3FF);
         wr(tccr_pkg::OFS_RELOAD, {24'h00FF, lfsr[7:0]});
         wr(tccr_pkg::OFS_COUNT, 32'hFFFE);
         wr(tccr_pkg::OFS_CTRL, 32'(1 + 16 * m));
         poll(0);
         rd(tccr_pkg::OFS_COUNT);
         k = m ? int'(mdl[5]) : 0;
         chk_rng("overflow load", k, k + 1, r);
         chk("ovf irq", 32'h1, {31'h0, timer_irq_o});
         wr(tccr_pkg::OFS_CTRL, 32'h0);
         wr(tccr_pkg::OFS_STATUS, 32'h1);
         repeat (2) @(posedge mclk_i);
         #1;
         chk("irq cleared", 32'h0, {31'h0, timer_irq_o});
      end
      // Capture on pin transitions, each pin also an interrupt
      wr(tccr_pkg::OFS_CCMODE, 32'h55);
      for (int ch = 0; ch < 4; ch++) begin
         lfsr = nxt(lfsr);
         wr(tccr_pkg::OFS_COUNT, {16'h0, lfsr[15:0]});
         u_tccr_pins_model.cc_toggle(ch, 3);
         repeat (3) @(posedge mclk_i);
         rd(tccr_pkg::OFS_CC0 + 8'(4 * ch));
         chk("pin capture", {16'h0, lfsr[15:0]}, r);
         chk("ext irq", 32'(1 << ch), {28'h0, ext_irq_o});
         wr(tccr_pkg::OFS_STATUS, 32'(1 << (6 + ch)));
      end
      // Capture on a low-byte write
      wr(tccr_pkg::OFS_CCMODE, 32'hAA);
      for (int ch = 0; ch < 4; ch++) begin
         lfsr = nxt(lfsr);
         wr(tccr_pkg::OFS_COUNT, {16'h0, lfsr[15:0]});
         apb(1'b1, tccr_pkg::OFS_CC0 + 8'(4 * ch), ~lfsr, 4'h1);
         rd(tccr_pkg::OFS_CC0 + 8'(4 * ch));
         chk("sw capture", {16'h0, lfsr[15:0]}, r);
      end
      // Both compare modes, pins watched across the overflow
      wr(tccr_pkg::OFS_CMPLVL, 32'h5);
      wr(tccr_pkg::OFS_CCMODE, 32'hFF);
      for (int cm = 0; cm < 2; cm++) begin
         for (int ch = 0; ch < 4; ch++) wr(tccr_pkg::OFS_CC0 + 8'(4 * ch), 32'(16'hFFF2 + 2 * ch));
         wr(tccr_pkg::OFS_STATUS, 32'h3FF);
         chk("pin enables", 32'hF, {28'h0, capcmp_pin_oe_o});
         wr(tccr_pkg::OFS_COUNT, 32'hFFF0);
         wr(tccr_pkg::OFS_CTRL, 32'(1 + 64 * cm));
         k = 0;
         #1;
         while (timer_irq_o !== 1'b1 && k < 400) begin
            prev = capcmp_pin_o;
            @(posedge mclk_i);
            #1;
            k++;
         end
         chk("pins on match", cm ? 32'h5 : 32'hF, {28'h0, prev});
         chk("pins on overflow", cm ? 32'h5 : 32'h0, {28'h0, capcmp_pin_o});
         chk("pin wire", cm ? 32'h5 : 32'h0, {28'h0, cc_wire});
         chk("cmp irq", 32'h1, {31'h0, cmp_irq_o});
         rd(tccr_pkg::OFS_STATUS);
         chk("match flags", 32'hF, {28'h0, r[5:2]});
         wr(tccr_pkg::OFS_CTRL, 32'h0);
      end
      give_verdict();
   end
endmodule : timer2_capture_compare_reload_test
